// [rtl/swp_top.sv]
// Notes on behaviour
// - step-size select low in an even state gives one-phase-on wave drive.
// - first half-step pulse after reset goes to state 2 or state 8 by direction.
// - wave drive steps by two: 2,4,6,8 forward or 8,6,4,2 backward.
// - every wave state energises exactly one bridge, the other carries no current.
// - an overcurrent fault pulls the shared enable pin low via open drain.
// - bridges stay off while the enable pin reads low, resume when it is high.
// - thermal trip indication switches both bridge enables off until it clears.
// - startup and reset put the sequencer in state 1.
// - select high steps one state per rising edge, up if direction high, else down.
// - select low in an odd state gives two-phase-on drive on odd states.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module swp_top
  import swp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o,
  // controller pins
  input  wire logic              step_clk_i,
  input  wire logic              rotation_direction_i,
  input  wire logic              half_step_sel_i,
  input  wire logic              seq_reset_n_i,
  // shared enable pin, open drain
  input  wire logic              en_pin_i,
  output logic                   en_pin_o,
  output logic                   en_pin_oe_n_o,
  // protection indications
  input  wire logic              overcurrent_detector_i,
  input  wire logic              overtemp_i,
  // bridge control
  output logic                   phase_a_o,
  output logic                   phase_b_o,
  output logic                   bridge_a_en_o,
  output logic                   bridge_b_en_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [PIN_N-1:0] pins_s;
  logic             step_s;
  logic             dir_s;
  logic             half_s;
  logic             seq_rst_n_s;
  logic             en_s;
  logic             oc_s;
  logic             th_s;

  swp_sync #(
    .WIDTH (PIN_N)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({step_clk_i, rotation_direction_i, half_step_sel_i, seq_reset_n_i,
              en_pin_i, overcurrent_detector_i, overtemp_i}),
    .q_o    (pins_s)
  );

  assign {step_s, dir_s, half_s, seq_rst_n_s, en_s, oc_s, th_s} = pins_s;

  // ****************************************************************
  // state
  // ****************************************************************
  swp_state_t r_reg;
  swp_state_t r_next;

  logic             step_rise;
  logic [SEQ_W-1:0] seq_inc;
  logic             bridges_on;
  logic             map_ph_a;
  logic             map_ph_b;
  logic             map_en_a;
  logic             map_en_b;

  // ****************************************************************
  // phase table
  // ****************************************************************
  swp_phase_map u_map (
    .seq_i  (r_reg.seq),
    .ph_a_o (map_ph_a),
    .ph_b_o (map_ph_b),
    .en_a_o (map_en_a),
    .en_b_o (map_en_b)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic        setup;
  logic        access;
  logic        hit;
  logic        wr;
  logic        rd_clear;
  logic [31:0] rd_val;
  logic [31:0] status_val;
  logic [INT_W-1:0] events;

  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign hit    = (paddr_i == OFS_CTRL) | (paddr_i == OFS_STATUS)
                | (paddr_i == OFS_INT_STAT) | (paddr_i == OFS_INT_MASK);
  assign wr       = access & pwrite_i & hit;
  assign rd_clear = access & ~pwrite_i & (paddr_i == OFS_INT_STAT);

  always_comb
  begin
    status_val = 32'h0;
    status_val[ST_STATE_LSB +: SEQ_W] = r_reg.seq;
    status_val[ST_WAVE]       = ~half_s & r_reg.seq[0];
    status_val[ST_NORMAL]     = ~half_s & ~r_reg.seq[0];
    status_val[ST_HALF]       = half_s;
    status_val[ST_OVERCUR]    = oc_s;
    status_val[ST_THERMAL]    = th_s;
    status_val[ST_BRIDGES_ON] = bridges_on;
    status_val[ST_EN_PIN]     = en_s;
  end

  always_comb
  begin
    rd_val = 32'h0;
    unique case (paddr_i)
      OFS_CTRL:     rd_val[CTRL_DRIVE_EN] = r_reg.ctrl_en;
      OFS_STATUS:   rd_val = status_val;
      OFS_INT_STAT: rd_val[INT_W-1:0] = r_reg.int_stat;
      OFS_INT_MASK: rd_val[INT_W-1:0] = r_reg.int_mask;
      default:      rd_val = 32'h0;
    endcase
  end

  // ****************************************************************
  // protection and sequencing
  // ****************************************************************
  assign step_rise  = step_s & ~r_reg.step_d;
  assign bridges_on = en_s & ~oc_s & ~th_s & r_reg.ctrl_en;
  assign seq_inc    = half_s ? SEQ_STEP_HALF : SEQ_STEP_FULL;

  always_comb
  begin
    events = '0;
    events[INT_STEP]    = step_rise & seq_rst_n_s;
    events[INT_OVERCUR] = oc_s & ~r_reg.oc_d;
    events[INT_THERMAL] = th_s & ~r_reg.th_d;
  end

  always_comb
  begin
    r_next        = r_reg;
    r_next.step_d = step_s;
    r_next.oc_d   = oc_s;
    r_next.th_d   = th_s;
    if (!seq_rst_n_s)
    begin
      r_next.seq = SEQ_INIT;
    end
    else if (step_rise)
    begin
      if (dir_s)
      begin
        r_next.seq = r_reg.seq + seq_inc;
      end
      else
      begin
        r_next.seq = r_reg.seq - seq_inc;
      end
    end
    r_next.ph_a    = map_ph_a;
    r_next.ph_b    = map_ph_b;
    r_next.en_a    = map_en_a & bridges_on;
    r_next.en_b    = map_en_b & bridges_on;
    r_next.pull_dn = oc_s;
    if (wr && paddr_i == OFS_CTRL)
    begin
      r_next.ctrl_en = pwdata_i[CTRL_DRIVE_EN];
    end
    if (wr && paddr_i == OFS_INT_MASK)
    begin
      r_next.int_mask = pwdata_i[INT_W-1:0];
    end
    r_next.int_stat = (r_reg.int_stat & {INT_W{~rd_clear}}) | events;
    if (setup)
    begin
      r_next.rdata = rd_val;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      r_reg          <= '0;
      r_reg.seq      <= SEQ_INIT;
      r_reg.ctrl_en  <= CTRL_RST;
      r_reg.int_mask <= INT_MASK_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata_o      = r_reg.rdata;
  assign pready_o      = 1'b1;
  assign pslverr_o     = access & ~hit;
  assign irq_o         = |(r_reg.int_stat & r_reg.int_mask);
  assign en_pin_o      = 1'b0;
  assign en_pin_oe_n_o = ~r_reg.pull_dn;
  assign phase_a_o     = r_reg.ph_a;
  assign phase_b_o     = r_reg.ph_b;
  assign bridge_a_en_o = r_reg.en_a;
  assign bridge_b_en_o = r_reg.en_b;

endmodule // swp_top
`default_nettype wire

// [rtl/swp_pkg.sv]
package swp_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          APB_AW          = 8;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_INT_STAT    = 8'h08;
  localparam logic [7:0]  OFS_INT_MASK    = 8'h0C;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int          CTRL_DRIVE_EN   = 0;
  localparam logic        CTRL_RST        = 1'b1;
  localparam logic [2:0]  INT_MASK_RST    = 3'h0;
  localparam int          INT_W           = 3;
  localparam int          INT_STEP        = 0;
  localparam int          INT_OVERCUR     = 1;
  localparam int          INT_THERMAL     = 2;
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_WAVE         = 4;
  localparam int          ST_NORMAL       = 5;
  localparam int          ST_HALF         = 6;
  localparam int          ST_OVERCUR      = 8;
  localparam int          ST_THERMAL      = 9;
  localparam int          ST_BRIDGES_ON   = 10;
  localparam int          ST_EN_PIN       = 11;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  localparam int          SEQ_W           = 3;
  localparam logic [2:0]  SEQ_INIT        = 3'h0;
  localparam logic [2:0]  SEQ_STEP_HALF   = 3'h1;
  localparam logic [2:0]  SEQ_STEP_FULL   = 3'h2;
  localparam int          PIN_N           = 7;

  typedef struct packed {
    logic [SEQ_W-1:0] seq;
    logic             step_d;
    logic             oc_d;
    logic             th_d;
    logic             ctrl_en;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [31:0]      rdata;
    logic             ph_a;
    logic             ph_b;
    logic             en_a;
    logic             en_b;
    logic             pull_dn;
  } swp_state_t;

endpackage

// [rtl/swp_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module swp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } swp_sync_t;

  swp_sync_t r_reg;
  swp_sync_t r_next;

  always_comb
  begin
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;

endmodule // swp_sync
`default_nettype wire

// [rtl/swp_phase_map.sv]
`timescale 1ns/1ns
`default_nettype none
module swp_phase_map
  import swp_pkg::*;
(
  input  wire logic [SEQ_W-1:0] seq_i,
  output logic                  ph_a_o,
  output logic                  ph_b_o,
  output logic                  en_a_o,
  output logic                  en_b_o
);

  // ****************************************************************
  // half-step table, index = state number - 1
  // ****************************************************************
  always_comb
  begin
    unique case (seq_i)
      3'h0:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'hF;
      3'h1:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'h3;
      3'h2:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'hB;
      3'h3:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'h8;
      3'h4:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'hA;
      3'h5:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'h2;
      3'h6:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'hE;
      3'h7:    {en_a_o, ph_a_o, en_b_o, ph_b_o} = 4'hC;
    endcase
  end

endmodule // swp_phase_map
`default_nettype wire

// [verification/swp_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module swp_sva (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       step_clk_i,
  input wire logic       seq_reset_n_i,
  input wire logic       en_pin_i,
  input wire logic       en_pin_oe_n_o,
  input wire logic       overcurrent_detector_i,
  input wire logic       overtemp_i,
  input wire logic       phase_a_o,
  input wire logic       phase_b_o,
  input wire logic       bridge_a_en_o,
  input wire logic       bridge_b_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic br_off = !bridge_a_en_o && !bridge_b_en_o;
  wire logic oc = overcurrent_detector_i;
  property p_oc_pull; $rose(oc) |-> ##[1:4] !en_pin_oe_n_o; endproperty
  a_oc_pull: assert property (p_oc_pull) else $error("no pull-down");
  property p_oc_hold; oc [*5] |-> !en_pin_oe_n_o; endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("pull-down dropped");
  property p_oc_rel; !oc [*5] |-> en_pin_oe_n_o; endproperty
  a_oc_rel: assert property (p_oc_rel) else $error("pull-down stuck");
  property p_oc_off; oc [*5] |-> br_off; endproperty
  a_oc_off: assert property (p_oc_off) else $error("bridges on in fault");
  property p_th_off; overtemp_i [*5] |-> br_off; endproperty
  a_th_off: assert property (p_th_off) else $error("bridges on when hot");
  property p_en_low; !en_pin_i [*5] |-> br_off; endproperty
  a_en_low: assert property (p_en_low) else $error("bridges on, pin low");
  property p_hold_ph;
    (!step_clk_i && seq_reset_n_i) [*6] |-> $stable(phase_a_o) && $stable(phase_b_o);
  endproperty
  a_hold_ph: assert property (p_hold_ph) else $error("phase moved");
  property p_one_on;
    (en_pin_i && !oc && !overtemp_i) [*6] |-> bridge_a_en_o || bridge_b_en_o;
  endproperty
  a_one_on: assert property (p_one_on) else $error("no bridge on");
endmodule // swp_sva
bind swp_top swp_sva i_swp_sva (.clk_i, .rstn_i, .step_clk_i, .seq_reset_n_i, .en_pin_i,
  .en_pin_oe_n_o, .overcurrent_detector_i, .overtemp_i, .phase_a_o, .phase_b_o,
  .bridge_a_en_o, .bridge_b_en_o);
`default_nettype wire

// [verification/swp_ctl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module swp_ctl_model (
  input  wire logic clk_i,
  output var logic  step_o,
  output var logic  dir_o,
  output var logic  half_o,
  output var logic  srst_n_o
);
  // every line driven from time zero
  initial
  begin
    {step_o, dir_o, half_o, srst_n_o} = 4'h1;
  end
  task automatic pulse(input logic d);
    dir_o <= d;
    repeat (3) @(posedge clk_i);
    step_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    step_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic seq_rst(input logic h);
    half_o <= h;
    srst_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    srst_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic sel(input logic h);
    half_o <= h;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // swp_ctl_model
`default_nettype wire

// [verification/swp_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
module swp_top_test
  import swp_pkg::*;
;
  localparam logic [31:0] TBL = 32'hCE2A8B3F;
  logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, oc, ot, ext_en, d;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o, irq_o, en_pin_o, en_pin_oe_n_o;
  logic        phase_a_o, phase_b_o, bridge_a_en_o, bridge_b_en_o;
  wire logic   step, dir, half, srst_n;
  wire logic   en_pin_i = en_pin_oe_n_o ? ext_en : en_pin_o;
  logic [64:0] q[$];
  logic [64:0] e;
  int          miscompares, n_checks, s;
  always #5 clk_i = ~clk_i;
  swp_top i_swp_top (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_o, .step_clk_i(step), .rotation_direction_i(dir),
    .half_step_sel_i(half), .seq_reset_n_i(srst_n), .en_pin_i, .en_pin_o, .en_pin_oe_n_o,
    .overcurrent_detector_i(oc), .overtemp_i(ot), .phase_a_o, .phase_b_o, .bridge_a_en_o,
    .bridge_b_en_o);
  swp_ctl_model i_swp_ctl_model (.clk_i, .step_o(step), .dir_o(dir), .half_o(half),
    .srst_n_o(srst_n));
  // ***
  // checks and bus
  // ***
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [31:0] m);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= dt;
    if (!w)
      q.push_back({a != OFS_CTRL && a != OFS_STATUS && a != OFS_INT_STAT && a != OFS_INT_MASK,
                   m, dt});
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    @(posedge clk_i);
    while (pready_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20)
    begin
      miscompares++;
      end_sim;
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i)
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && q.size() > 0)
    begin
      e = q.pop_front();
      chk(prdata_o & e[63:32], e[31:0]);
      chk(32'(pslverr_o), 32'(e[64]));
    end
  function automatic int nxt(int st, logic dr, logic h);
    int k;
    k = h ? 1 : 2;
    return dr ? (st - 1 + k) % 8 + 1 : (st + 7 - k) % 8 + 1;
  endfunction
  task st(input logic h);
    logic [31:0] x;
    x = 32'(s - 1);
    x[ST_HALF] = h;
    x[ST_WAVE] = !h && s % 2 == 0;
    x[ST_NORMAL] = !h && s % 2 == 1;
    apb(1'b0, OFS_STATUS, x, h ? 32'h47 : 32'h77);
    chk(32'({bridge_a_en_o, phase_a_o, bridge_b_en_o, phase_b_o}), 32'(TBL[4*(s-1) +: 4]));
  endtask
  // ***
  // main sequence
  // ***
  initial
  begin
    {clk_i, rstn_i, psel_i, penable_i, pwrite_i, oc, ot, paddr_i, pwdata_i} = '0;
    ext_en = 1'b1;
    void'($urandom(39086));
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, OFS_CTRL, 32'h1, 32'h1);
    apb(1'b0, OFS_INT_MASK, 32'h0, 32'h7);
    apb(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
    apb(1'b1, OFS_INT_MASK, 32'h1, 32'h0);
    i_swp_ctl_model.seq_rst(1'b1);
    s = 1;
    st(1'b1);
    repeat (6)
    begin
      d = 1'($urandom);
      i_swp_ctl_model.pulse(d);
      s = nxt(s, d, 1'b1);
      st(1'b1);
    end
    chk(32'(irq_o), 32'h1);
    apb(1'b0, OFS_INT_STAT, 32'h1, 32'h1);
    chk(32'(irq_o), 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h0, 32'h0);
    i_swp_ctl_model.pulse(1'b1);
    chk(32'(irq_o), 32'h0);
    apb(1'b0, OFS_INT_STAT, 32'h1, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      i_swp_ctl_model.seq_rst(1'b1);
      i_swp_ctl_model.pulse(i[0]);
      s = i ? 2 : 8;
      st(1'b1);
      i_swp_ctl_model.sel(1'b0);
      repeat (4)
      begin
        i_swp_ctl_model.pulse(i[0]);
        s = nxt(s, i[0], 1'b0);
        st(1'b0);
        chk(32'(bridge_a_en_o ^ bridge_b_en_o), 32'h1);
      end
    end
    i_swp_ctl_model.seq_rst(1'b0);
    s = 1;
    repeat (4)
    begin
      d = 1'($urandom);
      i_swp_ctl_model.pulse(d);
      s = nxt(s, d, 1'b0);
      st(1'b0);
    end
    oc <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(32'({en_pin_o, en_pin_oe_n_o, bridge_a_en_o, bridge_b_en_o}), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h100, 32'hD00);
    apb(1'b0, OFS_INT_STAT, 32'h2, 32'h2);
    ext_en <= 1'b0;
    oc <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(32'({en_pin_o, en_pin_oe_n_o, bridge_a_en_o, bridge_b_en_o}), 32'h4);
    ext_en <= 1'b1;
    repeat (6) @(posedge clk_i);
    st(1'b0);
    ot <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(32'({bridge_a_en_o, bridge_b_en_o}), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h200, 32'h600);
    apb(1'b0, OFS_INT_STAT, 32'h4, 32'h4);
    ot <= 1'b0;
    repeat (6) @(posedge clk_i);
    st(1'b0);
    apb(1'b1, OFS_CTRL, 32'h0, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(32'({bridge_a_en_o, bridge_b_en_o}), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h800, 32'hC00);
    apb(1'b1, OFS_CTRL, 32'h1, 32'h0);
    apb(1'b0, OFS_STATUS, 32'hC00, 32'hC00);
    end_sim;
  end
  initial
  begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    end_sim;
  end
endmodule // swp_top_test
`default_nettype wire
